// >>> hdl/fes_pkg.sv
/*
  Shared constants and types of the flash erase/program sequencer:
  register indices, key and select codes, result codes and timing.
  Assumes one 200 MHz clock and an 8-bit register port.
*/
package fes_pkg;
  // Register indices on the plain register port.
  localparam logic [7:0] A_KEY  = 8'h00; // Program key register.
  localparam logic [7:0] A_ASEL = 8'h01; // Array select register.
  localparam logic [7:0] A_CTRL = 8'h02; // Control/status register.
  localparam logic [7:0] A_TGT  = 8'h03; // Download target address.
  localparam logic [7:0] A_FREQ = 8'h04; // Operating frequency, MHz.
  localparam logic [7:0] A_BLK  = 8'h05; // Erase block select.
  localparam logic [7:0] A_PTR  = 8'h06; // Program data pointer.
  localparam logic [7:0] A_CALL = 8'h07; // Routine call address.
  localparam logic [7:0] A_RES  = 8'h08; // Routine result byte.
  localparam logic [7:0] A_DLR  = 8'h09; // Download result byte.
  // Control register fields.
  localparam int C_TRIG = 0; // Download trigger bit.
  localparam int C_ESEL = 1; // Select the erase routine.
  localparam int C_PSEL = 2; // Select the program routine.
  localparam int C_BUSY = 4; // Read only: download or operation runs.
  localparam int C_CHK  = 5; // Read only: start-up check running.
  localparam int C_BOOT = 6; // Read only: user boot mode.
  // Key codes and array select codes.
  localparam logic [7:0] KEY_DL   = 8'hA5; // Allows a download.
  localparam logic [7:0] KEY_PE   = 8'h5A; // Allows program/erase.
  localparam logic [7:0] ASEL_BT  = 8'hAA; // Boot user array shown.
  localparam logic [7:0] ASEL_MN  = 8'h00; // Main user array shown.
  // Entry offsets above the download start.
  localparam logic [7:0] ENT_RUN  = 8'h10; // Erase/program entry.
  localparam logic [7:0] ENT_INIT = 8'h20; // Initialization entry.
  // Accepted frequency range in MHz.
  localparam logic [7:0] FREQ_MIN = 8'h15; // 21 MHz.
  localparam logic [7:0] FREQ_MAX = 8'h22; // 34 MHz.
  // Result codes of the routines and of the download.
  localparam logic [7:0] RES_PASS = 8'h00; // Success.
  localparam logic [7:0] RES_ERR  = 8'h01; // Parameter/state error.
  localparam logic [7:0] RES_FREQ = 8'h02; // Frequency out of range.
  localparam logic [7:0] RES_ARR  = 8'h04; // Wrong array selected.
  localparam logic [7:0] DLR_SS   = 8'h04; // Bad routine selection.
  localparam logic [7:0] DLR_FK   = 8'h02; // Bad key at download.
  localparam logic [7:0] DLR_INI  = 8'hFF; // Value before download.
  // Reset defaults, array sizes and timing counts in cycles.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam int NUM_BLK   = 8;   // Main user array blocks.
  localparam int FLASH_TOP = 16;  // Pointer pages below this are flash.
  localparam int CHECK_CYC = 64;  // Start-up array check length.
  localparam int DL_CYC    = 32;  // Routine download length.
  localparam int OP_CYC    = 256; // Erase or program length.
  // Flash array view presented to the bus fabric.
  localparam logic [1:0] MAP_MAIN = 2'h0;
  localparam logic [1:0] MAP_BOOT = 2'h1;
  localparam logic [1:0] MAP_EMB  = 2'h2;
  // One erase or program request toward the flash macro.
  typedef struct packed {
    logic       erase; // Erase of one block runs.
    logic       prog;  // Program of one unit runs.
    logic [7:0] blk;   // Block or unit number.
  } fes_op_t;
endpackage : fes_pkg

// >>> hdl/fes_seq.sv
/*
  Flash erase/program sequencer: key register, array select, routine
  download, initialization, erase and program with a result byte.
  Assumes a CPU master on the plain register port, same clock, and a
  boot mode pin from outside that is synchronised here.
*/
`timescale 1ns/1ps
module fes_seq
  import fes_pkg::*;
#(
  parameter int P_CHECK_CYC = CHECK_CYC, // Start-up check cycles.
  parameter int P_DL_CYC    = DL_CYC,    // Download cycles.
  parameter int P_OP_CYC    = OP_CYC,    // Erase/program cycles.
  parameter int P_NUM_BLK   = NUM_BLK    // Main array blocks.
) (
  input  wire logic       i_clk,       // 200 MHz clock.
  input  wire logic       i_rst,       // Synchronous reset.
  input  wire logic       i_boot_mode, // Boot mode pin.
  input  wire logic [7:0] i_addr,      // Register index.
  input  wire logic [7:0] i_wdata,     // Write data.
  input  wire logic       i_wr,        // Write strobe.
  input  wire logic       i_rd,        // Read strobe.
  output logic      [7:0] o_rdata,     // Read data, next cycle.
  output logic            o_flash_rd,  // Flash may be read.
  output logic            o_irq_hold,  // Interrupts held off.
  output logic      [1:0] o_map,       // Array shown in flash space.
  output fes_op_t         o_op         // Running flash operation.
);
  // CHK runs the start-up array check after every reset, IDLE
  // accepts register traffic, DL copies a routine into RAM and OP
  // drives one erase or program pulse train into the array.
  typedef enum logic [1:0] {ST_CHK, ST_IDLE, ST_DL, ST_OP} fes_st_t;

  fes_st_t     state_q;              // Sequencer state.
  logic [15:0] cnt_q;                // Cycles left in this state.
  logic        bm1_q, bm2_q;         // Boot pin synchroniser.
  logic [7:0]  key_q, tgt_q, freq_q; // Software parameters.
  logic [7:0]  blk_q, ptr_q;
  logic        esel_q, psel_q;       // Routine selection bits.
  logic        boot_sel_q;           // Boot array shown.
  logic [7:0]  res_q, dlr_q;         // Result bytes.
  logic [7:0]  er_tgt_q, pr_tgt_q;   // Where each routine lives.
  logic        er_ok_q, pr_ok_q;     // Routine downloaded.
  logic        er_ini_q, pr_ini_q;   // Routine initialized.
  logic        dl_er_q;              // Download carries erase code.
  logic        run_er_q;             // Running op is an erase.
  logic [7:0]  ctrl_rd;              // Control register read view.

  // Entry decode of a call write. The CPU names the routine by the
  // address it jumps to, so only the two entry offsets above a
  // downloaded routine's start mean anything; any other address is
  // taken as a stray write and ignored.
  wire logic call = i_wr && i_addr == A_CALL && state_q == ST_IDLE;
  wire logic er_run = er_ok_q && i_wdata == 8'(er_tgt_q + ENT_RUN);
  wire logic pr_run = pr_ok_q && i_wdata == 8'(pr_tgt_q + ENT_RUN);
  wire logic er_ini = er_ok_q && i_wdata == 8'(er_tgt_q + ENT_INIT);
  wire logic pr_ini = pr_ok_q && i_wdata == 8'(pr_tgt_q + ENT_INIT);
  wire logic freq_ok = freq_q >= FREQ_MIN && freq_q <= FREQ_MAX;
  // Block numbers beyond the main array erase nothing at all.
  wire logic blk_ok = 32'(blk_q) < P_NUM_BLK;
  // Program data must come from RAM: a pointer page below the top
  // of flash is refused even when the data behind it are correct.
  wire logic ptr_ok = 32'(ptr_q) >= FLASH_TOP;
  // Boot array is never touched here; main must be shown in boot mode.
  wire logic arr_ok = !(bm2_q && boot_sel_q);
  // Two key codes guard two steps: one for the download, one for
  // the erase or program itself, so a single stray write can never
  // both fetch a routine and start it.
  wire logic key_pe = key_q == KEY_PE;
  // A trigger is honoured only from IDLE; one written during a
  // download or an operation is dropped without a trace.
  wire logic trig = i_wr && i_addr == A_CTRL && i_wdata[C_TRIG]
                    && state_q == ST_IDLE;
  // Exactly one routine may be selected for a download.
  wire logic dl_good = key_q == KEY_DL && (esel_q ^ psel_q);

  // The boot pin comes from outside; two flops before any use.
  // No reset here: the pin level is sampled all through reset, so
  // the second flop is settled well before the check ends.
  always_ff @(posedge i_clk) begin
    bm1_q <= i_boot_mode;
    bm2_q <= bm1_q;
  end

  // Main sequence: start-up check, download and flash operations.
  // The counter is loaded on entry to each timed state and counts
  // down to one; the state is left on the edge that sees one.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // Every reset, power-up or mid-run, repeats the array check.
      state_q  <= ST_CHK;
      cnt_q    <= 16'(P_CHECK_CYC);
      run_er_q <= 1'b0;
    end else begin
      case (state_q)
        ST_CHK: begin
          // Both arrays are checked; only register reads are accepted.
          // Interrupts stay held in boot mode until this state ends.
          if (cnt_q == 16'h0001) begin
            state_q <= ST_IDLE;
          end
          cnt_q <= cnt_q - 16'h0001;
        end
        ST_IDLE: begin
          // Trigger and call use different indices; one fires at most.
          if (trig && dl_good) begin
            state_q <= ST_DL;
            cnt_q   <= 16'(P_DL_CYC);
          end else if (call && key_pe && er_run && er_ini_q
                       && blk_ok && arr_ok) begin
            state_q  <= ST_OP;
            cnt_q    <= 16'(P_OP_CYC);
            run_er_q <= 1'b1;
          end else if (call && key_pe && pr_run && pr_ini_q
                       && ptr_ok && arr_ok) begin
            state_q  <= ST_OP;
            cnt_q    <= 16'(P_OP_CYC);
            run_er_q <= 1'b0;
          end
        end
        ST_DL, ST_OP: begin
          // Timed states: calls and triggers are refused until done.
          if (cnt_q == 16'h0001) begin
            state_q <= ST_IDLE;
          end
          cnt_q <= cnt_q - 16'h0001;
        end
        default: begin
          // No encoding is left unused; fall back to accepting traffic.
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Software-written parameters. Frozen while the engine is busy so
  // a stray write cannot alter a running erase or program.
  // Clearing the key after an operation restores software
  // protection; nothing here clears it on the host's behalf.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      key_q  <= RST_ZERO;
      tgt_q  <= RST_ZERO;
      freq_q <= RST_ZERO;
      blk_q  <= RST_ZERO;
      ptr_q  <= RST_ZERO;
      esel_q <= 1'b0;
      psel_q <= 1'b0;
    end else if (i_wr && state_q == ST_IDLE) begin
      if (i_addr == A_KEY) begin
        key_q <= i_wdata;
      end else if (i_addr == A_TGT) begin
        tgt_q <= i_wdata;
      end else if (i_addr == A_FREQ) begin
        freq_q <= i_wdata;
      end else if (i_addr == A_BLK) begin
        blk_q <= i_wdata;
      end else if (i_addr == A_PTR) begin
        ptr_q <= i_wdata;
      end else if (i_addr == A_CTRL) begin
        esel_q <= i_wdata[C_ESEL];
        psel_q <= i_wdata[C_PSEL];
      end
    end
  end

  // Array select. Boot mode starts on the boot array once the check
  // ends; the host may switch to the main array only in boot mode.
  // In user program mode the boot array is never shown, so the
  // write is ignored there and the main array stays in view.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      boot_sel_q <= 1'b0;
    end else if (state_q == ST_CHK && cnt_q == 16'h0001) begin
      boot_sel_q <= bm2_q;
    end else if (i_wr && i_addr == A_ASEL && state_q == ST_IDLE
                 && bm2_q) begin
      boot_sel_q <= i_wdata == ASEL_BT;
    end
  end

  // Download bookkeeping: each target keeps its own routine.
  // A routine downloaded onto the other routine's target overwrites
  // it, so that one is marked absent and must be fetched again.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dlr_q    <= DLR_INI;
      dl_er_q  <= 1'b0;
      er_tgt_q <= RST_ZERO;
      pr_tgt_q <= RST_ZERO;
      er_ok_q  <= 1'b0;
      pr_ok_q  <= 1'b0;
    end else if (trig && !dl_good) begin
      // Failed download leaves routines as they were.
      dlr_q <= (key_q != KEY_DL ? DLR_FK : RST_ZERO)
             | (esel_q ^ psel_q ? RST_ZERO : DLR_SS);
    end else if (trig) begin
      dl_er_q <= esel_q;
    end else if (state_q == ST_DL && cnt_q == 16'h0001) begin
      dlr_q <= RST_ZERO;
      if (dl_er_q) begin
        er_tgt_q <= tgt_q;
        er_ok_q  <= 1'b1;
        pr_ok_q  <= pr_ok_q && pr_tgt_q != tgt_q;
      end else begin
        pr_tgt_q <= tgt_q;
        pr_ok_q  <= 1'b1;
        er_ok_q  <= er_ok_q && er_tgt_q != tgt_q;
      end
    end
  end

  // Initialization flags; a fresh download needs a fresh init.
  // An out-of-range frequency leaves the routine uninitialised, so
  // any later run call with it returns an error and alters nothing.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      er_ini_q <= 1'b0;
      pr_ini_q <= 1'b0;
    end else if (state_q == ST_DL && cnt_q == 16'h0001) begin
      if (dl_er_q) begin
        er_ini_q <= 1'b0;
      end else begin
        pr_ini_q <= 1'b0;
      end
    end else if (call && er_ini) begin
      er_ini_q <= freq_ok;
    end else if (call && pr_ini) begin
      pr_ini_q <= freq_ok;
    end
  end

  // Result byte: the only state a routine call returns.
  // Errors are ranked: wrong array first, then key, initialisation
  // and parameter faults; a good run reports only when it ends.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      res_q <= RST_ZERO;
    end else if (state_q == ST_OP && cnt_q == 16'h0001) begin
      res_q <= RES_PASS;
    end else if (call && (er_ini || pr_ini)) begin
      res_q <= freq_ok ? RES_PASS : RES_FREQ;
    end else if (call && (er_run || pr_run) && !arr_ok) begin
      res_q <= RES_ARR;
    end else if (call && er_run && !(key_pe && er_ini_q && blk_ok)) begin
      res_q <= RES_ERR;
    end else if (call && pr_run && !(key_pe && pr_ini_q && ptr_ok)) begin
      res_q <= RES_ERR;
    end
  end

  // Control register read view. Bits without a function read zero.
  always_comb begin
    ctrl_rd         = RST_ZERO;
    ctrl_rd[C_ESEL] = esel_q;
    ctrl_rd[C_PSEL] = psel_q;
    ctrl_rd[C_BUSY] = state_q == ST_DL || state_q == ST_OP;
    ctrl_rd[C_CHK]  = state_q == ST_CHK;
    ctrl_rd[C_BOOT] = bm2_q;
  end

  // Read data stands in the cycle after the strobe only.
  // Zero outside that cycle keeps a shared read bus quiet; the
  // trade is one flop stage of latency on every read.
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_rd) begin
      o_rdata <= RST_ZERO;
    end else if (i_addr == A_KEY) begin
      o_rdata <= key_q;
    end else if (i_addr == A_ASEL) begin
      o_rdata <= boot_sel_q ? ASEL_BT : ASEL_MN;
    end else if (i_addr == A_CTRL) begin
      o_rdata <= ctrl_rd;
    end else if (i_addr == A_TGT) begin
      o_rdata <= tgt_q;
    end else if (i_addr == A_FREQ) begin
      o_rdata <= freq_q;
    end else if (i_addr == A_BLK) begin
      o_rdata <= blk_q;
    end else if (i_addr == A_PTR) begin
      o_rdata <= ptr_q;
    end else if (i_addr == A_RES) begin
      o_rdata <= res_q;
    end else if (i_addr == A_DLR) begin
      o_rdata <= dlr_q;
    end else begin
      // Unmapped indices read as zero.
      o_rdata <= RST_ZERO;
    end
  end

  // Outputs, registered from the current state_q, so they lag it by one cycle.
  // Flash stays readable through download and goes dark during an
  // erase or program, as any read then would corrupt the pulse.
  // The map shows the embedded store during a download, which is
  // why the trigger write itself must run from RAM.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_flash_rd <= 1'b0;
      o_irq_hold <= 1'b1;
      o_map      <= MAP_MAIN;
      o_op       <= '0;
    end else begin
      o_flash_rd <= state_q != ST_OP && state_q != ST_CHK;
      o_irq_hold <= state_q == ST_CHK && bm2_q;
      if (state_q == ST_DL) begin
        o_map <= MAP_EMB;
      end else if (boot_sel_q) begin
        o_map <= MAP_BOOT;
      end else begin
        o_map <= MAP_MAIN;
      end
      // The block number is shown even when idle; only erase or
      // prog tell the array that a pulse train runs.
      o_op.erase <= state_q == ST_OP && run_er_q;
      o_op.prog  <= state_q == ST_OP && !run_er_q;
      o_op.blk   <= blk_q;
    end
  end
endmodule : fes_seq

// >>> test/fes_seq_props.sv
/* Checker of the erase/program sequencer outputs.
   Assumes it is bound to fes_seq with one clock and a sync reset. */
`timescale 1ns/1ps
module fes_seq_props
  import fes_pkg::*;
#(
  parameter int P_OP_CYC  = OP_CYC,  // Operation length in cycles.
  parameter int P_NUM_BLK = NUM_BLK  // Main array blocks.
) (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_boot_mode,
  input wire logic       o_flash_rd,
  input wire logic       o_irq_hold,
  input wire logic [1:0] o_map,
  input wire fes_op_t    o_op
);
  logic        op_act; // Some operation drives the array.
  logic [15:0] len_q;  // Active cycles of the running operation.
  assign op_act = o_op.erase | o_op.prog;
  // A counter, since a repetition this long would slow the tools.
  always_ff @(posedge i_clk) begin
    if (i_rst || !op_act) begin
      len_q <= 16'h0000;
    end else begin
      len_q <= len_q + 16'h0001;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_op_no_flash: assert property (
    op_act |-> !o_flash_rd) else $error("Flash readable in operation.");
  a_op_length: assert property (
    $fell(op_act) |-> len_q == P_OP_CYC) else $error("Bad op length.");
  a_blk_steady: assert property (
    op_act && $past(op_act) |-> $stable(o_op.blk))
    else $error("Block changed in operation.");
  a_one_kind: assert property (
    !(o_op.erase && o_op.prog)) else $error("Erase and program together.");
  a_blk_range: assert property (
    o_op.erase |-> o_op.blk < P_NUM_BLK) else $error("Erase of bad block.");
  a_check_quiet: assert property (
    o_irq_hold |-> !o_flash_rd && !op_act) else $error("Active in check.");
  a_dl_no_op: assert property (
    o_map == MAP_EMB |-> !op_act) else $error("Operation in download.");
  a_boot_view: assert property (
    $fell(o_irq_hold) && i_boot_mode |-> ##[0:1] o_map == MAP_BOOT)
    else $error("Boot array not shown after check.");
  c_erase: cover property ($rose(o_op.erase));
  c_prog: cover property ($rose(o_op.prog));
  c_dl: cover property (o_map == MAP_EMB);
  c_boot: cover property ($fell(o_irq_hold) && i_boot_mode);
endmodule : fes_seq_props
bind fes_seq fes_seq_props #(.P_OP_CYC(P_OP_CYC), .P_NUM_BLK(P_NUM_BLK))
  u_props (.i_clk(i_clk), .i_rst(i_rst), .i_boot_mode(i_boot_mode),
  .o_flash_rd(o_flash_rd), .o_irq_hold(o_irq_hold), .o_map(o_map),
  .o_op(o_op));

// >>> test/fes_host.sv
/* Host CPU model that runs the procedure program on the register port.
   Assumes the slave never stalls and read data follow one cycle later. */
`timescale 1ns/1ps
module fes_host (
  input  wire logic       i_clk,   // Shared clock.
  input  wire logic [7:0] i_rdata, // Read data from the sequencer.
  output logic      [7:0] o_addr,  // Register index.
  output logic      [7:0] o_wdata, // Write data.
  output logic            o_wr,    // Write strobe.
  output logic            o_rd     // Read strobe.
);
  // Idle bus from time zero so nothing is taken during reset.
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // One-cycle write, launched right after an edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask : wr
  // One-cycle read; data are taken in the following cycle only.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1 d = i_rdata;
  endtask : rd
endmodule : fes_host

// >>> test/testbench.sv
/* Self-checking bench of the erase/program sequencer with a host model.
   Assumes shortened counts and results modelled from the rules. */
`timescale 1ns/1ps
module testbench
  import fes_pkg::*;
;
  // Targets sit apart and below the 128-byte stack page.
  localparam logic [7:0] T_E = 8'h40; // Erase routine target.
  localparam logic [7:0] T_P = 8'h80; // Program routine target.
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_boot_mode = 1'b0;
  logic [7:0] addr, wdata, o_rdata;
  logic wr, rd, o_flash_rd, o_irq_hold;
  logic [1:0] o_map;
  fes_op_t o_op;
  int n_fail = 0, checks_done = 0, cyc = 0;
  int key_m, frq_m, blk_m, ptr_m, sel_m, asel_m, boot_m, res_m, dlr_m;
  int init_m[2];     // Routine initialised, erase then program.
  int bq[$];         // Block numbers to erase in turn.
  logic [7:0] ks[3] = '{8'h00, KEY_DL, 8'h00};
  logic [7:0] ss[3] = '{8'h02, 8'h06, 8'h00};
  fes_seq #(.P_CHECK_CYC(4), .P_DL_CYC(4), .P_OP_CYC(8), .P_NUM_BLK(8))
    u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_boot_mode(i_boot_mode),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(o_rdata), .o_flash_rd(o_flash_rd),
    .o_irq_hold(o_irq_hold), .o_map(o_map), .o_op(o_op));
  fes_host u_host (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  // A hang ends the run as a failure.
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rchk(string nm, logic [7:0] a, int e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(nm, d, e[7:0]);
  endtask : rchk
  // Polls a control bit until clear, watching the outputs meanwhile.
  task automatic wait_idle(int b, int md, int blk);
    logic [7:0] d;
    int n;
    n = 0;
    d = 8'hFF;
    while (d[b] !== 1'b0 && n < 200) begin
      u_host.rd(A_CTRL, d);
      n++;
      if (d[b] === 1'b1 && md == 1) chk("map_dl", o_map, MAP_EMB);
      if (d[b] === 1'b1 && md >= 2) begin
        chk("flash_rd", o_flash_rd, 8'h00);
        chk("op_kind", {o_op.erase, o_op.prog}, md == 2 ? 2 : 1);
        if (md == 2) chk("op_blk", o_op.blk, blk[7:0]);
      end
    end
    if (n >= 200) chk("idle", d, 8'h00);
  endtask : wait_idle
  // Writes a register and advances the reference model.
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    int k;
    u_host.wr(a, d);
    k = (d == T_P + ENT_INIT || d == T_P + ENT_RUN) ? 1 : 0;
    case (a)
      A_KEY: key_m = d;
      A_FREQ: frq_m = d;
      A_BLK: blk_m = d;
      A_PTR: ptr_m = d;
      A_ASEL: if (boot_m) asel_m = (d == ASEL_BT) ? ASEL_BT : ASEL_MN;
      A_CTRL: begin
        if (d[C_TRIG]) begin
          dlr_m = (key_m != KEY_DL ? 2 : 0) | (sel_m[2:1] inside {1, 2} ? 0 : 4);
          if (dlr_m == 0) init_m[sel_m[2]] = 0;
        end
        sel_m = d;
      end
      A_CALL: begin
        if (d[5]) begin
          init_m[k] = (frq_m >= 21 && frq_m <= 34);
          res_m = init_m[k] ? 0 : 2;
        end else if (boot_m && asel_m == ASEL_BT) begin
          res_m = 4;
        end else begin
          res_m = (key_m != KEY_PE || !init_m[k] || (k == 0 && blk_m >= 8)
                   || (k == 1 && ptr_m < 16)) ? 1 : 0;
        end
      end
      default: ;
    endcase
  endtask : wreg
  task automatic dload(logic [7:0] key, logic [7:0] sel, logic [7:0] tgt);
    wreg(A_KEY, key);
    wreg(A_TGT, tgt);
    wreg(A_CTRL, sel);
    wreg(A_CTRL, sel | 8'h01);
    wait_idle(C_BUSY, 1, 0);
  endtask : dload
  task automatic reset_dut(logic b);
    i_boot_mode <= b;
    i_rst <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk("irq_hold", o_irq_hold, {7'h00, b});
    wait_idle(C_CHK, 0, 0);
    {key_m, sel_m, init_m[0], init_m[1], boot_m} = {32'd0, 32'd0, 64'd0, 32'(b)};
    asel_m = b ? ASEL_BT : ASEL_MN;
  endtask : reset_dut
  initial begin
    void'($urandom(66015));
    reset_dut(1'b0);
    rchk("dl_first", A_DLR, DLR_INI);
    rchk("unmapped", 8'h0A, 0);
    foreach (ks[i]) begin
      dload(ks[i], ss[i], T_E);
      rchk("dl_err", A_DLR, dlr_m);
    end
    dload(KEY_DL, 8'h02, T_E);
    rchk("dl_erase", A_DLR, dlr_m);
    dload(KEY_DL, 8'h04, T_P);
    rchk("dl_prog", A_DLR, dlr_m);
    rchk("tgt", A_TGT, T_P);
    wreg(A_FREQ, $urandom % 2 ? $urandom_range(20, 0) : $urandom_range(255, 35));
    wreg(A_CALL, T_E + ENT_INIT);
    rchk("init_bad", A_RES, res_m);
    wreg(A_FREQ, FREQ_MIN);
    wreg(A_CALL, T_E + ENT_INIT);
    rchk("init_e", A_RES, res_m);
    wreg(A_FREQ, FREQ_MAX);
    wreg(A_CALL, T_P + ENT_INIT);
    rchk("init_p", A_RES, res_m);
    wreg(A_CALL, T_E + ENT_RUN);
    rchk("dl_key", A_RES, res_m);
    wreg(A_KEY, KEY_PE);
    bq = '{0, 7, $urandom_range(255, 8), 0};
    foreach (bq[i]) begin
      wreg(A_BLK, bq[i]);
      wreg(A_CALL, T_E + ENT_RUN);
      wait_idle(C_BUSY, 2, bq[i]);
      rchk("erase", A_RES, res_m);
      chk("flash_on", o_flash_rd, 8'h01);
    end
    rchk("blk_kept", A_BLK, blk_m);
    rchk("frq_kept", A_FREQ, frq_m);
    for (int i = 0; i < 2; i++) begin
      wreg(A_PTR, i ? $urandom_range(255, 16) : $urandom_range(15, 0));
      wreg(A_CALL, T_P + ENT_RUN);
      wait_idle(C_BUSY, 3, 0);
      rchk("prog", A_RES, res_m);
    end
    wreg(A_KEY, 8'h00);
    wreg(A_CALL, T_E + ENT_RUN);
    rchk("key_clr", A_RES, res_m);
    reset_dut(1'b1);
    rchk("asel_boot", A_ASEL, ASEL_BT);
    rchk("ctrl_boot", A_CTRL, 1 << C_BOOT);
    chk("map_boot", o_map, MAP_BOOT);
    dload(KEY_DL, 8'h02, T_E);
    wreg(A_FREQ, $urandom_range(34, 21));
    wreg(A_CALL, T_E + ENT_INIT);
    wreg(A_KEY, KEY_PE);
    wreg(A_BLK, $urandom_range(7, 0));
    for (int i = 0; i < 2; i++) begin
      wreg(A_CALL, T_E + ENT_RUN);
      wait_idle(C_BUSY, 2, blk_m);
      rchk("boot_run", A_RES, res_m);
      wreg(A_ASEL, i ? ASEL_BT : ASEL_MN);
      rchk("asel", A_ASEL, asel_m);
      chk("map", o_map, i ? MAP_BOOT : MAP_MAIN);
    end
    give_verdict();
  end
endmodule : testbench
